/* rtl/adc_request_sequencer.sv */
// Request sequencer for one successive-approximation converter.
// Assumes the analog core returns its result by the end of the timed window.
`timescale 1ns/1ps
module adc_request_sequencer #(
  parameter int NUM_CH = 11,
  parameter int NUM_CH_B = 5,
  parameter int STC_W = 8,
  parameter int DIV_W = 8,
  parameter int QDEPTH = 4,
  parameter int QP_W = 2
) (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic [STC_W-1:0] i_sample_time_count,
  input wire logic [DIV_W-1:0] i_analog_clk_div,
  input wire logic i_mode_8bit,
  input wire logic i_slow_wake,
  input wire logic [3:0] i_trig_src,
  input wire logic [1:0] i_par_trig_sel,
  input wire logic [1:0] i_que_trig_sel,
  input wire logic [NUM_CH-1:0] i_par_mask,
  input wire logic [1:0] i_par_prio,
  input wire logic [1:0] i_que_prio,
  input wire logic i_que_push,
  input wire logic [3:0] i_que_chan,
  output logic o_que_full,
  input wire logic i_insert_req,
  input wire logic [3:0] i_insert_chan,
  input wire logic i_sync_slave,
  input wire logic i_sync_start,
  output logic o_sync_start,
  input wire logic i_ext_mux_en,
  input wire logic [3:0] i_ext_mux_chan,
  output logic [2:0] o_ext_mux_sel,
  output logic o_ana_pwr_on,
  output logic [3:0] o_ana_chan,
  output logic o_ana_start,
  input wire logic [9:0] i_ana_result,
  input wire logic i_fifo_en,
  input wire logic [7:0] i_wfr_en,
  input wire logic [1:0] i_acc_count,
  input wire logic [11:0] i_lim_lo,
  input wire logic [11:0] i_lim_hi,
  input wire logic [1:0] i_irq_sel,
  input wire logic i_rd_en,
  input wire logic [2:0] i_rd_idx,
  output logic [15:0] o_rd_data,
  output logic o_rd_valid,
  output logic o_irq,
  output logic o_limit_evt,
  output logic o_transfer_req,
  input wire logic [NUM_CH-1:0] i_port_a_digital_input_disable,
  input wire logic [NUM_CH-1:0] i_pin_a,
  output logic [NUM_CH-1:0] o_din_a,
  input wire logic [NUM_CH_B-1:0] i_port_b_digital_input_disable,
  input wire logic [NUM_CH_B-1:0] i_pin_b,
  output logic [NUM_CH_B-1:0] o_din_b
);
  localparam int CW = adc_seq_pkg::CH_W;
  localparam int RW = adc_seq_pkg::RES_W;
  localparam int IW = adc_seq_pkg::RIDX_W;
  localparam int WW = adc_seq_pkg::WAKE_W;

  adc_seq_pkg::state_t state;
  adc_seq_pkg::src_t cur_src;
  logic [adc_seq_pkg::WAKE_W-1:0] wake_cnt;
  logic [3:0] trig_q;
  logic [NUM_CH-1:0] par_pend;
  logic ins_pend;
  logic [CW-1:0] ins_chan;
  logic que_armed;
  logic [CW-1:0] q_mem [QDEPTH];
  logic [QP_W-1:0] q_wr;
  logic [QP_W-1:0] q_rd;
  logic [QP_W:0] q_cnt;
  logic [RW-1:0] acc_sum;
  logic [1:0] acc_n;
  logic [RW-1:0] res_val;
  logic [IW-1:0] fifo_ptr;
  logic [adc_seq_pkg::NUM_RES-1:0] res_valid;
  logic conv_done;
  logic [CW-1:0] par_chan;

  // Trigger edges from the selected event lines
  wire logic par_trig = i_trig_src[i_par_trig_sel] & ~trig_q[i_par_trig_sel];
  wire logic que_trig = i_trig_src[i_que_trig_sel] & ~trig_q[i_que_trig_sel];

  always_comb begin
    par_chan = '0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (par_pend[i]) begin
        par_chan = CW'(i);
      end
    end
  end

  wire logic [NUM_CH-1:0] below_mask = NUM_CH'((1 << par_chan) - 1);
  wire logic q_empty = (q_cnt == '0);
  wire logic [CW-1:0] que_head = q_mem[q_rd];
  wire logic par_req = |par_pend;
  wire logic que_req = que_armed && !q_empty;
  wire logic any_req = ins_pend | par_req | que_req;
  wire logic sync_ok = !i_sync_slave || i_sync_start;
  wire logic arb_go = (state == adc_seq_pkg::ST_ARB) && any_req && sync_ok;
  // Insert outranks both sources; equal priority favours the parallel scan
  wire logic par_wins = par_req && (!que_req || i_par_prio >= i_que_prio);
  wire logic grant_ins = arb_go && ins_pend;
  wire logic grant_par = arb_go && !ins_pend && par_wins;
  wire logic grant_que = arb_go && !ins_pend && !par_wins;
  wire logic [CW-1:0] grant_chan = ins_pend ? ins_chan : (par_wins ? par_chan : que_head);
  wire logic q_push = i_que_push && !o_que_full;
  wire logic [NUM_CH-1:0] par_clr = grant_par ? (NUM_CH'(1) << par_chan) : '0;
  wire logic [NUM_CH-1:0] next_par = (par_pend & ~par_clr) | (par_trig ? i_par_mask : '0);
  wire logic [adc_seq_pkg::WAKE_W-1:0] wake_len = i_slow_wake
    ? WW'(adc_seq_pkg::WAKE_SLOW_CYC)
    : WW'(adc_seq_pkg::WAKE_FAST_CYC);

  // Accumulation and limit check
  wire logic [RW-1:0] acc_total = acc_sum + {{(RW - adc_seq_pkg::DATA_W){1'b0}}, i_ana_result};
  wire logic acc_last = (acc_n == i_acc_count);
  wire logic lim_out = (res_val < i_lim_lo) || (res_val > i_lim_hi);
  // Chained registers fill in turn; otherwise the channel picks the slot
  wire logic [IW-1:0] res_idx = i_fifo_en ? fifo_ptr : o_ana_chan[IW-1:0];
  wire logic blocked = i_wfr_en[res_idx] & res_valid[res_idx];
  wire logic res_we = (state == adc_seq_pkg::ST_STORE) && !blocked;
  wire logic scan_end = (cur_src == adc_seq_pkg::SRC_PAR) && !par_req;
  wire logic irq_hit = (i_irq_sel == adc_seq_pkg::IRQ_ON_RESULT)
    || (i_irq_sel == adc_seq_pkg::IRQ_ON_LIMIT && lim_out)
    || (i_irq_sel == adc_seq_pkg::IRQ_ON_SCAN_END && scan_end);
  wire logic mux_step = res_we && i_ext_mux_en && o_ana_chan == i_ext_mux_chan;

  conv_timer #(
    .STC_W(STC_W),
    .DIV_W(DIV_W)
  ) u_timer (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .i_start(o_ana_start),
    .i_mode_8bit(i_mode_8bit),
    .i_stc(i_sample_time_count),
    .i_div(i_analog_clk_div),
    .o_done(conv_done)
  );

  result_store #(
    .NUM(adc_seq_pkg::NUM_RES),
    .IDX_W(IW),
    .W(adc_seq_pkg::WORD_W)
  ) u_store (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .i_we(res_we),
    .i_widx(res_idx),
    .i_wdata({o_ana_chan, res_val}),
    .i_re(i_rd_en),
    .i_ridx(i_rd_idx),
    .o_rdata(o_rd_data),
    .o_valid(res_valid)
  );

  // Request sources
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      trig_q <= '0;
      par_pend <= '0;
      ins_pend <= 1'b0;
      ins_chan <= '0;
      que_armed <= 1'b0;
      q_wr <= '0;
      q_rd <= '0;
      q_cnt <= '0;
      o_que_full <= 1'b0;
    end else begin
      trig_q <= i_trig_src;
      par_pend <= next_par;
      // A new insert request beats the grant clearing the old one
      ins_pend <= (ins_pend & ~grant_ins) | i_insert_req;
      if (i_insert_req) begin
        ins_chan <= i_insert_chan;
      end
      if (que_trig) begin
        que_armed <= 1'b1;
      end else if (q_empty) begin
        que_armed <= 1'b0;
      end
      if (q_push) begin
        q_wr <= q_wr + 1'b1;
      end
      if (grant_que) begin
        q_rd <= q_rd + 1'b1;
      end
      q_cnt <= q_cnt + (q_push ? 1'b1 : 1'b0) - (grant_que ? 1'b1 : 1'b0);
      o_que_full <= (q_cnt + (q_push ? 1'b1 : 1'b0) - (grant_que ? 1'b1 : 1'b0)) == (QP_W+1)'(QDEPTH);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (q_push) begin
      q_mem[q_wr] <= i_que_chan;
    end
  end

  // Conversion sequencing and power control
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= adc_seq_pkg::ST_OFF;
      cur_src <= adc_seq_pkg::SRC_NONE;
      wake_cnt <= '0;
      o_ana_pwr_on <= 1'b0;
      o_ana_chan <= '0;
      o_ana_start <= 1'b0;
      o_sync_start <= 1'b0;
      acc_sum <= '0;
      acc_n <= '0;
      res_val <= '0;
    end else begin
      o_ana_start <= 1'b0;
      o_sync_start <= 1'b0;
      case (state)
        adc_seq_pkg::ST_OFF: begin
          if (any_req) begin
            o_ana_pwr_on <= 1'b1;
            wake_cnt <= wake_len;
            state <= adc_seq_pkg::ST_WAKE;
          end
        end
        adc_seq_pkg::ST_WAKE: begin
          if (wake_cnt == '0) begin
            state <= adc_seq_pkg::ST_ARB;
          end else begin
            wake_cnt <= wake_cnt - 1'b1;
          end
        end
        adc_seq_pkg::ST_ARB: begin
          if (!any_req) begin
            o_ana_pwr_on <= 1'b0;
            state <= adc_seq_pkg::ST_OFF;
          end else if (arb_go) begin
            o_ana_chan <= grant_chan;
            o_ana_start <= 1'b1;
            o_sync_start <= 1'b1;
            cur_src <= grant_ins ? adc_seq_pkg::SRC_INS
                     : (grant_par ? adc_seq_pkg::SRC_PAR : adc_seq_pkg::SRC_QUE);
            state <= adc_seq_pkg::ST_CONV;
          end
        end
        adc_seq_pkg::ST_CONV: begin
          // Nothing aborts a running conversion
          if (conv_done) begin
            if (acc_last) begin
              res_val <= acc_total;
              acc_sum <= '0;
              acc_n <= '0;
              state <= adc_seq_pkg::ST_STORE;
            end else begin
              acc_sum <= acc_total;
              acc_n <= acc_n + 1'b1;
              state <= adc_seq_pkg::ST_ARB;
            end
          end
        end
        adc_seq_pkg::ST_STORE: begin
          if (!blocked) begin
            state <= adc_seq_pkg::ST_ARB;
          end
        end
        default: begin
          state <= adc_seq_pkg::ST_OFF;
        end
      endcase
    end
  end

  // Result events, read status, digital inputs
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      fifo_ptr <= '0;
      o_ext_mux_sel <= '0;
      o_irq <= 1'b0;
      o_limit_evt <= 1'b0;
      o_transfer_req <= 1'b0;
      o_rd_valid <= 1'b0;
      o_din_a <= '0;
      o_din_b <= '0;
    end else begin
      o_irq <= res_we && irq_hit;
      o_limit_evt <= res_we && lim_out;
      o_transfer_req <= res_we;
      if (res_we && i_fifo_en) begin
        fifo_ptr <= fifo_ptr + 1'b1;
      end
      if (mux_step) begin
        o_ext_mux_sel <= o_ext_mux_sel + 1'b1;
      end
      if (i_rd_en) begin
        o_rd_valid <= res_valid[i_rd_idx];
      end
      o_din_a <= i_pin_a & ~i_port_a_digital_input_disable;
      o_din_b <= i_pin_b & ~i_port_b_digital_input_disable;
    end
  end

  logic [15:0] pwr_age;
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pwr_age <= '0;
    end else if (!o_ana_pwr_on) begin
      pwr_age <= '0;
    end else if (pwr_age != 16'hFFFF) begin
      pwr_age <= pwr_age + 1'b1;
    end
  end

  a_off_unpowered: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (state == adc_seq_pkg::ST_OFF) |-> !o_ana_pwr_on)
    else $error("analog powered while idle");
  a_wake_first: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    o_ana_start |-> pwr_age >= 16'(wake_len) + 16'h2)
    else $error("start before wake-up elapsed");
  a_insert_wins: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (arb_go && ins_pend) |=> cur_src == adc_seq_pkg::SRC_INS && o_ana_chan == $past(ins_chan))
    else $error("insert not granted first");
  a_par_lowest: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    grant_par |-> (par_pend & below_mask) == '0)
    else $error("parallel order broken");
  a_queue_head: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    grant_que |=> o_ana_chan == $past(que_head) && o_ana_start)
    else $error("queue order broken");
  a_no_abort: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (state == adc_seq_pkg::ST_CONV && !conv_done) |=> state == adc_seq_pkg::ST_CONV)
    else $error("conversion abandoned");
  a_wfr_hold: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    res_we |-> !(i_wfr_en[res_idx] && res_valid[res_idx]))
    else $error("unread result overwritten");
  a_din_gate: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    1'b1 |=> o_din_a == $past(i_pin_a & ~i_port_a_digital_input_disable))
    else $error("digital input gate wrong");
endmodule : adc_request_sequencer

/* rtl/adc_seq_pkg.sv */
// Constants shared by the conversion request sequencer.
// Assumes a 125 MHz system clock; analog timing is derived from it.
package adc_seq_pkg;
  localparam int SYS_PERIOD_NS = 8;
  localparam int FAST_WAKE_NS = 1000;
  localparam int SLOW_WAKE_NS = 10000;
  // Longest wait rounds down to whole cycles
  localparam int WAKE_FAST_CYC = FAST_WAKE_NS / SYS_PERIOD_NS;
  localparam int WAKE_SLOW_CYC = SLOW_WAKE_NS / SYS_PERIOD_NS;
  localparam int WAKE_W = 11;
  localparam int CH_W = 4;
  localparam int DATA_W = 10;
  localparam int RES_W = 12;
  localparam int NUM_RES = 8;
  localparam int RIDX_W = 3;
  localparam int WORD_W = CH_W + RES_W;
  localparam int MUX_W = 3;
  localparam logic [4:0] CONV_BASE_10 = 5'h0D;
  localparam logic [4:0] CONV_BASE_8 = 5'h0B;
  localparam logic [1:0] SYS_TAIL = 2'h2;
  localparam logic [1:0] IRQ_ON_RESULT = 2'h0;
  localparam logic [1:0] IRQ_ON_LIMIT = 2'h1;
  localparam logic [1:0] IRQ_ON_SCAN_END = 2'h2;
  typedef enum logic [1:0] {SRC_NONE, SRC_INS, SRC_PAR, SRC_QUE} src_t;
  typedef enum logic [2:0] {ST_OFF, ST_WAKE, ST_ARB, ST_CONV, ST_STORE} state_t;
endpackage : adc_seq_pkg

/* rtl/conv_timer.sv */
// Conversion timer: analog clock divider plus sample and convert phases.
// Assumes i_start is a one-cycle pulse issued only while idle.
`timescale 1ns/1ps
module conv_timer #(
  parameter int STC_W = 8,
  parameter int DIV_W = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_start,
  input wire logic i_mode_8bit,
  input wire logic [STC_W-1:0] i_stc,
  input wire logic [DIV_W-1:0] i_div,
  output logic o_done
);
  logic busy;
  logic [STC_W:0] ticks;
  logic [DIV_W-1:0] div_cnt;
  logic [1:0] tail;
  // Analog period is i_div+1 system clocks
  wire logic [STC_W:0] base = i_mode_8bit ? (STC_W+1)'(adc_seq_pkg::CONV_BASE_8)
                                           : (STC_W+1)'(adc_seq_pkg::CONV_BASE_10);
  wire logic [STC_W:0] load = base + {1'b0, i_stc};
  wire logic tick_end = (div_cnt == '0);

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      busy <= 1'b0;
      ticks <= '0;
      div_cnt <= '0;
      tail <= '0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        busy <= 1'b1;
        ticks <= load;
        div_cnt <= i_div;
        tail <= adc_seq_pkg::SYS_TAIL;
      end else if (busy && ticks != '0) begin
        div_cnt <= tick_end ? i_div : div_cnt - 1'b1;
        if (tick_end) begin
          ticks <= ticks - 1'b1;
        end
      end else if (busy) begin
        tail <= tail - 1'b1;
        if (tail == 2'h1) begin
          busy <= 1'b0;
          o_done <= 1'b1;
        end
      end
    end
  end

  logic [19:0] elapsed;
  logic [19:0] expect_cyc;
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      elapsed <= '0;
      expect_cyc <= '0;
    end else if (i_start) begin
      elapsed <= '0;
      // Widen before multiplying so long sample counts cannot wrap the product
      expect_cyc <= 20'(load) * (20'(i_div) + 20'h1) + 20'h2;
    end else if (busy) begin
      elapsed <= elapsed + 1'b1;
    end
  end

  a_conv_length: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    o_done |-> elapsed == expect_cyc)
    else $error("conversion length wrong");
endmodule : conv_timer

/* rtl/result_store.sv */
// Eight result words with valid flags; read data come from a register.
// A read clears the valid flag unless a write hits the same word.
`timescale 1ns/1ps
module result_store #(
  parameter int NUM = 8,
  parameter int IDX_W = 3,
  parameter int W = 16
) (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_we,
  input wire logic [IDX_W-1:0] i_widx,
  input wire logic [W-1:0] i_wdata,
  input wire logic i_re,
  input wire logic [IDX_W-1:0] i_ridx,
  output logic [W-1:0] o_rdata,
  output logic [NUM-1:0] o_valid
);
  logic [W-1:0] mem [NUM];
  logic [NUM-1:0] next_valid;

  for (genvar g = 0; g < NUM; g++) begin : g_ent
    wire logic wr = i_we && i_widx == IDX_W'(g);
    wire logic rd = i_re && i_ridx == IDX_W'(g);
    // Write beats a clearing read in the same cycle
    assign next_valid[g] = wr | (o_valid[g] & ~rd);
    always_ff @(posedge i_sys_clk) begin
      if (wr) begin
        mem[g] <= i_wdata;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_valid <= '0;
      o_rdata <= '0;
    end else begin
      o_valid <= next_valid;
      if (i_re) begin
        o_rdata <= mem[i_ridx];
      end
    end
  end

  a_read_clears: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (i_re && !(i_we && i_widx == i_ridx)) |=> !o_valid[$past(i_ridx)])
    else $error("read did not clear valid");
endmodule : result_store

/* dv/analog_core_model.sv */
// Stand-in for the analog core: answers each start with a code built from the channel.
// Assumes start is a one-cycle pulse issued only while the core is powered.
`timescale 1ns/1ps
module analog_core_model (
  input wire logic i_sys_clk,
  input wire logic i_pwr_on,
  input wire logic i_start,
  input wire logic [3:0] i_chan,
  output logic [9:0] o_result
);
  logic [3:0] chan;
  initial chan = 4'h0;
  initial o_result = 10'h155;
  always @(posedge i_sys_clk) begin
    if (i_start) chan <= i_chan;
    // An unpowered core gives no valid code, so toggle rather than hold the last one
    o_result <= i_pwr_on ? {chan, 6'h2A} : ~o_result;
  end
endmodule : analog_core_model

/* dv/adc_request_sequencer_tb.sv */
// Self-checking bench for the request sequencer with an analog core stand-in.
// Assumes the hand-over timing: store one cycle after done, transfer one after store.
`timescale 1ns/1ps
module adc_request_sequencer_tb;
  logic i_sys_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic [7:0] i_sample_time_count, i_analog_clk_div, i_wfr_en;
  logic i_mode_8bit, i_slow_wake, i_que_push, i_insert_req, i_sync_slave, i_sync_start;
  logic i_ext_mux_en, i_fifo_en, i_rd_en;
  logic [3:0] i_trig_src, i_que_chan, i_insert_chan, i_ext_mux_chan;
  logic [1:0] i_par_trig_sel, i_que_trig_sel, i_par_prio, i_que_prio, i_acc_count, i_irq_sel;
  logic [10:0] i_par_mask, i_port_a_digital_input_disable, i_pin_a, o_din_a;
  logic [4:0] i_port_b_digital_input_disable, i_pin_b, o_din_b;
  logic [11:0] i_lim_lo, i_lim_hi;
  logic [2:0] i_rd_idx, o_ext_mux_sel;
  logic [9:0] i_ana_result;
  logic [15:0] o_rd_data;
  logic [3:0] o_ana_chan;
  logic o_que_full, o_sync_start, o_ana_pwr_on, o_ana_start, o_rd_valid, o_irq, o_limit_evt, o_transfer_req;
  int fails = 0;
  int compares = 0;
  int cyc = 0;
  logic [3:0] exp_chan[$];
  int exp_dur[$];

  always #4 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) cyc <= cyc + 1;

  adc_request_sequencer adc_request_sequencer_i (.*);
  analog_core_model analog_core_model_i (.i_sys_clk(i_sys_clk), .i_pwr_on(o_ana_pwr_on),
    .i_start(o_ana_start), .i_chan(o_ana_chan), .o_result(i_ana_result));

  task automatic stop_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test

  task automatic compare_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : compare_val

  task automatic compare_dur(input int exp, input int got);
    compares++;
    if (got != exp) begin
      fails++;
      $display("unexpected duration expected %0d seen %0d", exp, got);
    end
  endtask : compare_dur

  task automatic tick;
    @(posedge i_sys_clk);
    #1;
  endtask : tick

  // Start sampled by the timer, window, two tail cycles, store and transfer
  function automatic int conv_len(input int base);
    return (base + int'(i_sample_time_count)) * (int'(i_analog_clk_div) + 1) + 5;
  endfunction : conv_len

  task automatic wait_drained;
    for (int n = 0; n < 8000 && exp_dur.size() > 0; n++) tick();
    compare_val("pending", 16'h0, 16'(exp_dur.size()));
  endtask : wait_drained

  task automatic pulse_trig(input int bit_no);
    i_trig_src[bit_no] = 1'b1;
    tick();
    i_trig_src[bit_no] = 1'b0;
  endtask : pulse_trig

  task automatic read_slot(input logic [2:0] idx, input logic [15:0] exp, input logic exp_v);
    i_rd_idx = idx;
    i_rd_en = 1'b1;
    tick();
    compare_val("read data", exp, o_rd_data);
    compare_val("read valid", {15'h0, exp_v}, {15'h0, o_rd_valid});
    // One idle cycle so a following read raises the strobe on a fresh edge
    i_rd_en = 1'b0;
    tick();
  endtask : read_slot

  // Watches outputs and retires the oldest expectation when a result appears
  initial begin : monitor
    int t0;
    logic [3:0] ch;
    t0 = 0;
    ch = 4'h0;
    forever begin
      @(posedge i_sys_clk);
      #2;
      if (o_transfer_req === 1'b1 && exp_dur.size() > 0) begin
        compare_dur(exp_dur.pop_front(), cyc - t0);
        compare_val("irq", 16'h1, {15'h0, o_irq});
        compare_val("limit event", {15'h0, (12'({ch, 6'h2A}) > i_lim_hi)}, {15'h0, o_limit_evt});
      end
      if (o_ana_start === 1'b1 && exp_chan.size() > 0) begin
        t0 = cyc;
        ch = o_ana_chan;
        compare_val("channel", {12'h0, exp_chan.pop_front()}, {12'h0, o_ana_chan});
        compare_val("sync start", 16'h1, {15'h0, o_sync_start});
      end
    end
  end

  initial begin : watchdog
    #400000;
    fails++;
    stop_test();
  end

  initial begin : driver
    logic [10:0] mask;
    void'($urandom(57109));
    {i_mode_8bit, i_slow_wake, i_que_push, i_insert_req, i_sync_slave, i_sync_start} = 6'h00;
    // External mux follows channel 10; queue listens to event line 1
    {i_ext_mux_en, i_fifo_en, i_rd_en, i_trig_src, i_que_chan, i_insert_chan} = 15'h4000;
    {i_par_trig_sel, i_que_trig_sel, i_par_prio, i_que_prio} = 8'h14;
    {i_acc_count, i_irq_sel, i_rd_idx, i_ext_mux_chan, i_wfr_en} = 19'h00A00;
    i_lim_lo = 12'h000;
    i_lim_hi = 12'h200;
    i_sample_time_count = 8'($urandom_range(3));
    i_analog_clk_div = 8'($urandom_range(1));
    i_par_mask = 11'h000;
    {i_pin_a, i_port_a_digital_input_disable, i_pin_b, i_port_b_digital_input_disable} = 32'h0;
    repeat (2) @(posedge i_sys_clk);
    #1;
    i_arst_n = 1'b1;
    compare_val("idle outputs", 16'h0, {12'h0, o_ana_pwr_on, o_ana_start, o_irq, o_transfer_req});
    // Parallel scan: slot 2 is written only by channel 10
    mask = (11'($urandom) & 11'h7FB) | 11'h400;
    i_par_mask = mask;
    for (int i = 0; i < 11; i++) begin
      if (mask[i]) begin
        exp_chan.push_back(4'(i));
        exp_dur.push_back(conv_len(13));
      end
    end
    pulse_trig(0);
    wait_drained();
    repeat (4) tick();
    compare_val("power", 16'h0, {15'h0, o_ana_pwr_on});
    compare_val("mux select", 16'h1, {13'h0, o_ext_mux_sel});
    read_slot(3'h2, {4'hA, 2'h0, 4'hA, 6'h2A}, 1'b1);
    read_slot(3'h2, {4'hA, 2'h0, 4'hA, 6'h2A}, 1'b0);
    // Queue of four, a refused fifth push, and an insert during the first conversion
    i_mode_8bit = 1'b1;
    exp_chan.delete();
    exp_chan = '{4'h3, 4'h9, 4'h1, 4'h2, 4'h5};
    repeat (5) exp_dur.push_back(conv_len(11));
    i_que_push = 1'b1;
    for (int k = 0; k < 5; k++) begin
      i_que_chan = k == 0 ? 4'h3 : k == 1 ? 4'h1 : k == 2 ? 4'h2 : k == 3 ? 4'h5 : 4'h7;
      tick();
    end
    i_que_push = 1'b0;
    compare_val("queue full", 16'h1, {15'h0, o_que_full});
    pulse_trig(1);
    for (int n = 0; n < 3000 && o_ana_start !== 1'b1; n++) tick();
    i_insert_chan = 4'h9;
    i_insert_req = 1'b1;
    tick();
    i_insert_req = 1'b0;
    wait_drained();
    // Digital input disable per pin
    i_pin_a = 11'($urandom);
    i_port_a_digital_input_disable = 11'($urandom);
    i_pin_b = 5'($urandom);
    i_port_b_digital_input_disable = 5'($urandom);
    repeat (2) tick();
    compare_val("port a input", {5'h0, i_pin_a & ~i_port_a_digital_input_disable}, {5'h0, o_din_a});
    compare_val("port b input", {11'h0, i_pin_b & ~i_port_b_digital_input_disable}, {11'h0, o_din_b});
    stop_test();
  end
endmodule : adc_request_sequencer_tb
